// File: tmsl_regs.sv
`timescale 1ns/1ns
module tmsl_regs #(
   parameter int PWRUP_CYC = tmsl_pkg::PWRUP_CYCLES, // Power-up length in cycles
   parameter logic [7:0] MAKER_CODE = 8'h5a,         // Arbitrary value
   parameter logic [7:0] REV_CODE   = 8'h10          // Arbitrary value
) (
   input  wire logic                  clock,        // Core clock, 250 MHz
   input  wire logic                  srst,         // Sync reset, high
   input  wire tmsl_pkg::tmsl_regreq_s req,         // Register access request
   output logic [7:0]                 rdata,        // Read data, registered
   input  wire tmsl_pkg::tmsl_conv_s  conv,         // Converter side state
   output logic                       one_shot,     // Start one conversion, pulse
   output logic [10:0]                remote_u_out, // Unsigned remote readout
   output logic [10:0]                remote_s_out, // Signed remote readout
   output logic                       warn_n,       // Warning output, low active
   output logic                       crit_n        // Critical output, low active
);
   import tmsl_pkg::*;

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   localparam int CW = $clog2(PWRUP_CYC + 1); // Power-up counter width
   generate
      if (PWRUP_CYC < 1) begin : g_bad_pwrup
         $error("PWRUP_CYC must be at least 1");
      end
      // The count is cast from an int, so keep it well inside that range
      if (CW > 30) begin : g_wide_pwrup
         $error("PWRUP_CYC too large for the power-up counter");
      end
   endgenerate

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0]    remote_warn_limit_unsigned; // Remote warning limit
   logic [7:0]    remote_critical_limit;      // Remote critical limit
   logic [7:0]    local_shared_limit;         // Local shared limit
   logic [7:0]    common_hysteresis;          // Common hysteresis
   logic [CW-1:0] pwr_cnt;                    // Power-up counter
   logic          not_ready;                  // Power-up still running
   logic          start_pending;              // One-shot issued, busy not yet seen
   logic          busy_level;                 // Conversion running
   logic          remote_warn_flag;           // Remote warning state
   logic          remote_critical_flag;       // Remote critical state
   logic          local_combined_flag;        // Local shared state
   logic [7:0]    alarm_status_primary;       // Status 1 image
   logic [7:0]    alarm_status_secondary;     // Status 2 image
   logic [7:0]    next_rdata;                 // Read mux result
   logic          wr_lim;                     // Write to a limit register
   logic [7:0]    cmp_temp  [3];              // Comparator temperatures
   logic [7:0]    cmp_limit [3];              // Comparator limits
   logic [2:0]    cmp_flag;                   // Comparator results

   // ----------------------------------------
   // Writable registers
   // ----------------------------------------
   // Only the four read/write offsets store; all others drop the write
   // A write and a read in one cycle return the old value
   // Reserved hysteresis bits are masked off on the way in
   always_ff @(posedge clock) begin
      if (srst) begin
         remote_warn_limit_unsigned <= RST_RWARN_LIM;
         remote_critical_limit      <= RST_RCRIT_LIM;
         local_shared_limit         <= RST_LOCAL_LIM;
         common_hysteresis          <= RST_HYST;
      end else if (req.wr) begin
         case (req.addr)
            OFS_RWARN_LIM: remote_warn_limit_unsigned <= req.wdata;
            OFS_RCRIT_LIM: remote_critical_limit      <= req.wdata;
            OFS_LOCAL_LIM: local_shared_limit         <= req.wdata;
            OFS_HYST:      common_hysteresis          <= req.wdata & HYST_MASK;
            default: begin
               // Read-only or unmapped: nothing stored
            end
         endcase
      end
   end

   // ----------------------------------------
   // Power-up sequence
   // ----------------------------------------
   // Counts from reset; not_ready falls when the count is reached
   // The counter stops once done, so it never wraps back to not ready
   always_ff @(posedge clock) begin
      if (srst) begin
         pwr_cnt   <= '0;
         not_ready <= 1'b1;
      end else if (not_ready) begin
         if (pwr_cnt == CW'(PWRUP_CYC - 1)) begin
            not_ready <= 1'b0;
         end
         pwr_cnt <= pwr_cnt + CW'(1);
      end
   end

   // ----------------------------------------
   // One-shot conversion start
   // ----------------------------------------
   // A pending flag covers the gap until the converter raises busy
   // Refused while busy, so one write never starts two conversions
   always_ff @(posedge clock) begin
      if (srst) begin
         one_shot      <= 1'b0;
         start_pending <= 1'b0;
      end else begin
         one_shot <= req.wr && req.addr == OFS_ONE_SHOT && conv.standby && !busy_level;
         if (req.wr && req.addr == OFS_ONE_SHOT && conv.standby && !busy_level) begin
            start_pending <= 1'b1;
         end else if (conv.busy) begin
            start_pending <= 1'b0;
         end
      end
   end

   // Busy covers both the request and the running conversion
   assign busy_level = conv.busy | start_pending;

   // ----------------------------------------
   // Limit comparators
   // ----------------------------------------
   // Index 0 remote warning, 1 remote critical, 2 local shared
   // Whole degrees only; the fraction bits play no part in alarms
   always_comb begin
      cmp_temp[0]  = conv.remote_u[10:3];
      cmp_temp[1]  = conv.remote_u[10:3];
      cmp_temp[2]  = conv.local_t;
      cmp_limit[0] = remote_warn_limit_unsigned;
      cmp_limit[1] = remote_critical_limit;
      cmp_limit[2] = local_shared_limit;
   end

   generate
      for (genvar i = 0; i < 3; i++) begin : g_cmp
         tmsl_hyst_cmp u_cmp (
            .clock (clock),
            .srst  (srst),
            .temp  (cmp_temp[i]),
            .limit (cmp_limit[i]),
            .hyst  (common_hysteresis),
            .flag  (cmp_flag[i])
         );
      end
   endgenerate

   assign remote_warn_flag     = cmp_flag[0];
   assign remote_critical_flag = cmp_flag[1];
   assign local_combined_flag  = cmp_flag[2];

   // ----------------------------------------
   // Alarm pins
   // ----------------------------------------
   // Local flag drives both pins since one limit serves both
   // Registered, so the pins never glitch while a flag updates
   always_ff @(posedge clock) begin
      if (srst) begin
         warn_n <= 1'b1;
         crit_n <= 1'b1;
      end else begin
         warn_n <= !(remote_warn_flag | local_combined_flag);
         crit_n <= !(remote_critical_flag | local_combined_flag);
      end
   end

   // ----------------------------------------
   // Remote readouts
   // ----------------------------------------
   // A faulty diode gives nonsense, so the readouts are pinned
   // Clean readings pass through with one cycle of delay
   always_ff @(posedge clock) begin
      if (srst) begin
         remote_u_out <= FAULT_UNSIGNED;
         remote_s_out <= FAULT_SIGNED;
      end else if (conv.fault) begin
         remote_u_out <= FAULT_UNSIGNED;
         remote_s_out <= FAULT_SIGNED;
      end else begin
         remote_u_out <= conv.remote_u;
         remote_s_out <= conv.remote_s;
      end
   end

   // ----------------------------------------
   // Status images
   // ----------------------------------------
   // Reserved positions are constant zero, never state
   // Busy also covers a start that the converter has not yet seen
   always_comb begin
      alarm_status_primary                = 8'h00;
      alarm_status_primary[BIT_S1_BUSY]   = busy_level;
      alarm_status_primary[BIT_S1_RWARN]  = remote_warn_flag;
      alarm_status_primary[BIT_S1_FAULT]  = conv.fault;
      alarm_status_primary[BIT_S1_RCRIT]  = remote_critical_flag;
      alarm_status_primary[BIT_S1_LOCAL]  = local_combined_flag;
      alarm_status_secondary              = 8'h00;
      alarm_status_secondary[BIT_S2_NRDY] = not_ready;
      alarm_status_secondary[BIT_S2_MODEL] = conv.model_sel & conv.sense_en;
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Unmapped and write-only offsets read as zero
   always_comb begin
      case (req.addr)
         OFS_STAT1:     next_rdata = alarm_status_primary;
         OFS_RWARN_LIM: next_rdata = remote_warn_limit_unsigned;
         OFS_RCRIT_LIM: next_rdata = remote_critical_limit;
         OFS_LOCAL_LIM: next_rdata = local_shared_limit;
         OFS_HYST:      next_rdata = common_hysteresis;
         OFS_STAT2:     next_rdata = alarm_status_secondary;
         OFS_MAKER_ID:  next_rdata = MAKER_CODE;
         OFS_REV_ID:    next_rdata = REV_CODE;
         default:       next_rdata = 8'h00;
      endcase
   end

   // Read data held until the next read
   // Holding it lets a slow host collect the byte when it likes
   always_ff @(posedge clock) begin
      if (srst) begin
         rdata <= 8'h00;
      end else if (req.rd) begin
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Any write that lands in a limit or the hysteresis register
   assign wr_lim = req.wr && (req.addr == OFS_RWARN_LIM || req.addr == OFS_RCRIT_LIM ||
                              req.addr == OFS_LOCAL_LIM || req.addr == OFS_HYST);

   // All checks run on the core clock and sleep through reset
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   // Status reads mirror the live state of the cycle before
   chk_busy_bit: assert property (req.rd && req.addr == OFS_STAT1 |=> rdata[7] == $past(busy_level))
      else $error("busy bit does not match conversion state");
   chk_stat1_reserved: assert property (req.rd && req.addr == OFS_STAT1 |=> rdata[6:5] == 2'b00 && !rdata[3])
      else $error("status 1 reserved bits not zero");
   // Fault and limit flags land in their own bit places
   chk_fault_bit: assert property (req.rd && req.addr == OFS_STAT1 |=> rdata[2] == $past(conv.fault))
      else $error("fault bit wrong");
   chk_fault_readout: assert property (conv.fault |=>
         remote_u_out == FAULT_UNSIGNED && remote_s_out == FAULT_SIGNED)
      else $error("faulty diode readouts not pinned");
   chk_flag_bits: assert property (req.rd && req.addr == OFS_STAT1 |=>
         rdata[4] == $past(remote_warn_flag) && rdata[1:0] == $past({remote_critical_flag, local_combined_flag}))
      else $error("limit flags misplaced in status 1");
   // Status 2 low bits are wired to zero
   chk_stat2_low: assert property (req.rd && req.addr == OFS_STAT2 |=> rdata[5:0] == 6'h00)
      else $error("status 2 low bits not zero");
   // Not ready ends exactly at the end of the count
   chk_not_ready: assert property ($fell(not_ready) |-> $past(pwr_cnt) == CW'(PWRUP_CYC - 1))
      else $error("not ready fell at wrong count");
   // Model detect needs both the model and the sensing mode
   chk_model_bit: assert property (req.rd && req.addr == OFS_STAT2 |=>
         rdata[6] == $past(conv.model_sel && conv.sense_en))
      else $error("model detect bit wrong");
   // Hysteresis upper bits can never hold state
   chk_hyst_upper: assert property (common_hysteresis[7:5] == 3'b000)
      else $error("hysteresis upper bits set");
   // Read-only places keep the limits untouched
   chk_ro_write: assert property (req.wr && !wr_lim |=> $stable({remote_warn_limit_unsigned,
         remote_critical_limit, local_shared_limit, common_hysteresis}))
      else $error("write to read-only offset changed a limit");
   // An accepted start gives one pulse and raises busy
   chk_one_shot: assert property (req.wr && req.addr == OFS_ONE_SHOT && conv.standby && !busy_level |=>
         one_shot && busy_level ##1 !one_shot)
      else $error("one-shot did not give a single start");
   // Revision code is fixed at build time
   chk_rev_read: assert property (req.rd && req.addr == OFS_REV_ID |=> rdata == REV_CODE)
      else $error("revision read wrong");

   // Each read/write register takes the written byte on the next edge; hysteresis takes it masked by HYST_MASK
   chk_rwarn_write: assert property (req.wr && req.addr == OFS_RWARN_LIM |=>
         remote_warn_limit_unsigned == $past(req.wdata))
      else $error("remote warning limit not written");
   chk_rcrit_write: assert property (req.wr && req.addr == OFS_RCRIT_LIM |=>
         remote_critical_limit == $past(req.wdata))
      else $error("remote critical limit not written");
   chk_local_write: assert property (req.wr && req.addr == OFS_LOCAL_LIM |=>
         local_shared_limit == $past(req.wdata))
      else $error("local limit not written");
   chk_hyst_write: assert property (req.wr && req.addr == OFS_HYST |=>
         common_hysteresis == ($past(req.wdata) & HYST_MASK))
      else $error("hysteresis not written");
   // Refused starts leave the pulse low
   chk_start_refused: assert property (req.wr && req.addr == OFS_ONE_SHOT &&
         (!conv.standby || busy_level) |=> !one_shot)
      else $error("one-shot pulsed on a refused start");
   // Not ready bit follows the power-up sequence
   chk_nrdy_bit: assert property (req.rd && req.addr == OFS_STAT2 |=> rdata[7] == $past(not_ready))
      else $error("not ready bit wrong");
   // A healthy diode passes its readings straight through
   chk_readout_pass: assert property (!conv.fault |=>
         remote_u_out == $past(conv.remote_u) && remote_s_out == $past(conv.remote_s))
      else $error("readouts not passed through");
   // One shared local limit raises both alarm pins
   chk_local_pins: assert property (local_combined_flag |=> !warn_n && !crit_n)
      else $error("local flag did not drive both pins");

endmodule : tmsl_regs

// File: tmsl_pkg.sv
package tmsl_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_STAT1      = 8'h02; // Primary alarm status
   localparam logic [7:0] OFS_RWARN_LIM  = 8'h07; // Remote warning limit
   localparam logic [7:0] OFS_ONE_SHOT   = 8'h0f; // One-shot trigger, write only
   localparam logic [7:0] OFS_RCRIT_LIM  = 8'h19; // Remote critical limit
   localparam logic [7:0] OFS_LOCAL_LIM  = 8'h20; // Local shared limit
   localparam logic [7:0] OFS_HYST       = 8'h21; // Common hysteresis
   localparam logic [7:0] OFS_STAT2      = 8'h33; // Secondary alarm status
   localparam logic [7:0] OFS_MAKER_ID   = 8'hfe; // Maker identity
   localparam logic [7:0] OFS_REV_ID     = 8'hff; // Die revision identity

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_S1_BUSY    = 7; // Conversion running
   localparam int BIT_S1_RWARN   = 4; // Remote warning flag
   localparam int BIT_S1_FAULT   = 2; // Remote diode fault
   localparam int BIT_S1_RCRIT   = 1; // Remote critical flag
   localparam int BIT_S1_LOCAL   = 0; // Local combined flag
   localparam int BIT_S2_NRDY    = 7; // Power-up not finished
   localparam int BIT_S2_MODEL   = 6; // Transistor model detect
   localparam logic [7:0] HYST_MASK = 8'h1f; // Writable hysteresis bits

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_RWARN_LIM = 8'h55; // 85 degrees
   localparam logic [7:0] RST_RCRIT_LIM = 8'h6e; // 110 degrees
   localparam logic [7:0] RST_LOCAL_LIM = 8'h55; // 85 degrees
   localparam logic [7:0] RST_HYST      = 8'h0a; // 10 degrees
   localparam logic [10:0] FAULT_UNSIGNED = 11'h000; // Reads 0 degrees
   localparam logic [10:0] FAULT_SIGNED   = 11'h400; // Reads -128 degrees

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ      = 250;                    // Core clock rate
   localparam int PWRUP_MS     = 30;                     // Power-up sequence
   localparam int PWRUP_CYCLES = PWRUP_MS * CLK_MHZ * 1000; // 7.5 M cycles

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] addr;  // Register offset
      logic       wr;    // Write strobe
      logic       rd;    // Read strobe
      logic [7:0] wdata; // Write data
   } tmsl_regreq_s;

   typedef struct packed {
      logic       busy;        // Converter running
      logic       fault;       // Remote diode fault
      logic       model_sel;   // Discrete transistor model chosen
      logic       sense_en;    // Transistor-equation sensing on
      logic       standby;     // Device stopped
      logic [10:0] remote_u;   // Raw unsigned remote reading
      logic [10:0] remote_s;   // Raw signed remote reading
      logic [7:0] local_t;     // Local temperature, whole degrees
   } tmsl_conv_s;

endpackage : tmsl_pkg

// File: tmsl_hyst_cmp.sv
`timescale 1ns/1ns
module tmsl_hyst_cmp (
   input  wire logic       clock, // Core clock
   input  wire logic       srst,  // Sync reset, high
   input  wire logic [7:0] temp,  // Temperature, whole degrees
   input  wire logic [7:0] limit, // Alarm limit
   input  wire logic [7:0] hyst,  // Hysteresis amount
   output logic            flag   // Alarm state
);
   import tmsl_pkg::*;

   // ----------------------------------------
   // Release threshold
   // ----------------------------------------
   logic [7:0] release_lvl; // Limit minus hysteresis, floored

   // Floor at zero so a big hysteresis never wraps to a high level
   always_comb begin
      if (hyst > limit) begin
         release_lvl = 8'h00;
      end else begin
         release_lvl = limit - hyst;
      end
   end

   // ----------------------------------------
   // Flag state
   // ----------------------------------------
   // Set above limit, hold in the band, clear below release
   always_ff @(posedge clock) begin
      if (srst) begin
         flag <= 1'b0;
      end else if (temp > limit) begin
         flag <= 1'b1;
      end else if (temp < release_lvl) begin
         flag <= 1'b0;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   chk_flag_set: assert property (temp > limit |=> flag)
      else $error("flag did not set above limit");
   chk_flag_hold: assert property (flag && temp >= release_lvl |=> flag)
      else $error("flag cleared inside hysteresis band");

endmodule : tmsl_hyst_cmp

// File: tmsl_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Host side register access model
// ----------------------------------------
module tmsl_host_model (
   input  wire logic                  clock, // Core clock
   output tmsl_pkg::tmsl_regreq_s     req,   // Request to the block
   input  wire logic [7:0]            rdata  // Registered read data
);
   import tmsl_pkg::*;

   // Idle bus at time zero
   initial begin
      req = '0;
   end

   // Released address and data show inverted values and the strobes drop low, so a stale copy never matches
   task automatic release_bus();
      req.wr    = 1'b0;
      req.rd    = 1'b0;
      req.addr  = ~req.addr;
      req.wdata = ~req.wdata;
   endtask : release_bus

   // One write, held across the taking edge; the caller picks the address
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      req.addr  = a;
      req.wdata = d;
      req.wr    = 1'b1;
      @(negedge clock);
      release_bus();
   endtask : wr_reg

   // One read; data is registered, so it is settled half a cycle later
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      req.addr = a;
      req.rd   = 1'b1;
      @(negedge clock);
      d = rdata;
      release_bus();
   endtask : rd_reg

endmodule : tmsl_host_model

// File: test_temp_monitor_status_limit_regs.sv
`timescale 1ns/1ns
module test_temp_monitor_status_limit_regs;
   import tmsl_pkg::*;
   localparam int         PWRUP = 20;    // Short power-up for simulation
   localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
   localparam logic [7:0] REV   = 8'h07; // Arbitrary value

   typedef struct packed {
      logic       wr;    // Write before the read
      logic [7:0] addr;  // Register offset
      logic [7:0] wdata; // Data written
      logic [7:0] exp;   // Expected read back
   } tmsl_row_s;

   logic         clock;            // Core clock
   logic         srst;             // Sync reset
   tmsl_regreq_s req;              // Host request
   logic [7:0]   rdata;            // Read data
   tmsl_conv_s   conv;             // Converter state
   logic         one_shot;         // Start pulse
   logic [10:0]  remote_u_out;     // Unsigned readout
   logic [10:0]  remote_s_out;     // Signed readout
   logic         warn_n;           // Warning pin
   logic         crit_n;           // Critical pin
   int           fails = 0;        // Mismatches
   int           checks_done = 0;  // Comparisons
   int           cycles = 0;       // Timeout counter
   tmsl_row_s    rows [14] = '{'{1'b0, 8'h07, 8'h00, 8'h55}, '{1'b0, 8'h19, 8'h00, 8'h6e},
      '{1'b0, 8'h20, 8'h00, 8'h55}, '{1'b0, 8'h21, 8'h00, 8'h0a}, '{1'b1, 8'h07, 8'h3c, 8'h3c},
      '{1'b1, 8'h19, 8'hff, 8'hff}, '{1'b1, 8'h20, 8'h00, 8'h00}, '{1'b1, 8'h21, 8'hff, 8'h1f},
      '{1'b1, 8'h02, 8'hff, 8'h00}, '{1'b1, 8'hfe, 8'h00, MAKER}, '{1'b1, 8'hff, 8'h00, REV},
      '{1'b1, 8'h0f, 8'h00, 8'h00}, '{1'b1, 8'h40, 8'ha5, 8'h00}, '{1'b1, 8'h33, 8'hff, 8'h00}};
   logic [7:0]   tseq [6] = '{8'h40, 8'h41, 8'h3c, 8'h3b, 8'h3a, 8'h51}; // Remote temps
   logic [7:0]   sexp [6] = '{8'h00, 8'h10, 8'h10, 8'h10, 8'h00, 8'h12}; // Status seen

   tmsl_regs #(.PWRUP_CYC(PWRUP), .MAKER_CODE(MAKER), .REV_CODE(REV)) u_tmsl_regs (
      .clock(clock), .srst(srst), .req(req), .rdata(rdata), .conv(conv), .one_shot(one_shot),
      .remote_u_out(remote_u_out), .remote_s_out(remote_s_out), .warn_n(warn_n), .crit_n(crit_n));
   tmsl_host_model u_tmsl_host_model (.clock(clock), .req(req), .rdata(rdata));

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Run needs about 185 cycles; the ceiling leaves wide margin
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         finish_test();
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_tmsl_host_model.rd_reg(a, d);
      chk({3'h0, d}, {3'h0, exp}, "register read");
   endtask : rchk

   // Flags take one cycle, pins one more
   task automatic settle();
      repeat (3) @(negedge clock);
   endtask : settle

   task automatic do_reset();
      srst = 1'b1;
      repeat (12) @(negedge clock);
      chk({3'h0, rdata}, 11'h000, "reset rdata");
      chk(remote_s_out, 11'h400, "reset signed readout");
      chk({8'h00, one_shot, warn_n, crit_n}, 11'h003, "reset pins");
      srst = 1'b0;
      @(negedge clock);
   endtask : do_reset

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      srst = 1'b1;
      conv = '0;
      do_reset();
      rchk(OFS_STAT2, 8'h80);
      repeat (PWRUP) @(negedge clock);
      rchk(OFS_STAT2, 8'h00);
      $display("Test done: power-up");
      // Reset values, read/write limits, read-only and unmapped places
      foreach (rows[i]) begin
         if (rows[i].wr)
            u_tmsl_host_model.wr_reg(rows[i].addr, rows[i].wdata);
         rchk(rows[i].addr, rows[i].exp);
      end
      $display("Test done: register table");
      conv.model_sel = 1'b1;
      conv.sense_en  = 1'b1;
      settle();
      rchk(OFS_STAT2, 8'h40);
      conv.sense_en = 1'b0;
      settle();
      rchk(OFS_STAT2, 8'h00);
      $display("Test done: model detect");
      // Low remote temperature so no limit flag joins the fault bit
      conv.remote_u = 11'h050;
      conv.remote_s = 11'h050;
      conv.fault    = 1'b1;
      settle();
      rchk(OFS_STAT1, 8'h04);
      chk(remote_u_out, 11'h000, "fault unsigned");
      chk(remote_s_out, 11'h400, "fault signed");
      conv.fault = 1'b0;
      settle();
      chk(remote_u_out, 11'h050, "clear unsigned");
      chk(remote_s_out, 11'h050, "clear signed");
      $display("Test done: diode fault");
      // Warn at 64, critical at 80, hysteresis 5: clears below 59
      u_tmsl_host_model.wr_reg(OFS_RWARN_LIM, 8'h40);
      u_tmsl_host_model.wr_reg(OFS_RCRIT_LIM, 8'h50);
      u_tmsl_host_model.wr_reg(OFS_HYST, 8'h05);
      u_tmsl_host_model.wr_reg(OFS_LOCAL_LIM, 8'h7f);
      for (int i = 0; i < 6; i++) begin
         conv.remote_u = {tseq[i], 3'h0};
         settle();
         rchk(OFS_STAT1, sexp[i]);
         chk({9'h000, warn_n, crit_n}, {9'h000, ~sexp[i][4], ~sexp[i][1]}, "alarm pins");
      end
      conv.remote_u = 11'h000;
      conv.local_t  = 8'h80;
      settle();
      rchk(OFS_STAT1, 8'h01);
      chk({9'h000, warn_n, crit_n}, 11'h000, "local pins");
      conv.local_t = 8'h00;
      settle();
      $display("Test done: limit flags");
      conv.standby = 1'b1;
      u_tmsl_host_model.wr_reg(OFS_ONE_SHOT, 8'h00);
      chk({10'h000, one_shot}, 11'h001, "start pulse");
      rchk(OFS_STAT1, 8'h80);
      u_tmsl_host_model.wr_reg(OFS_ONE_SHOT, 8'h00);
      chk({10'h000, one_shot}, 11'h000, "start while busy");
      conv.busy = 1'b1;
      settle();
      rchk(OFS_STAT1, 8'h80);
      conv.busy = 1'b0;
      settle();
      rchk(OFS_STAT1, 8'h00);
      conv.standby = 1'b0;
      u_tmsl_host_model.wr_reg(OFS_ONE_SHOT, 8'h00);
      chk({10'h000, one_shot}, 11'h000, "start when running");
      $display("Test done: one-shot");
      do_reset();
      rchk(OFS_RWARN_LIM, 8'h55);
      rchk(OFS_STAT2, 8'h80);
      $display("Test done: second reset");
      finish_test();
   end

endmodule : test_temp_monitor_status_limit_regs
